// file: dtc_regs.svh
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// register word addresses (byte address = 4 * index)
`define DTC_IDX_MODE 4'h0
`define DTC_IDX_CTRL 4'h1
`define DTC_IDX_T0L 4'h2
`define DTC_IDX_T0H 4'h3
`define DTC_IDX_T1L 4'h4
`define DTC_IDX_T1H 4'h5
`define DTC_IDX_AFR 4'h6

// mode register fields, per timer nibble
`define DTC_MODE_RESET 8'h00
`define DTC_MODE_GATE 3
`define DTC_MODE_SRC 2
`define DTC_MODE_T1_LSB 4

// control register fields
`define DTC_CTRL_RESET 8'h00
`define DTC_CTRL_T1_FLAG 7
`define DTC_CTRL_T1_RUN 6
`define DTC_CTRL_T0_FLAG 5
`define DTC_CTRL_T0_RUN 4

// advanced function register
`define DTC_AFR_RESET 1'b1
`define DTC_AFR_CDC 0

// machine cycle lengths in oscillator periods
`define DTC_CYC_LONG 4'hC
`define DTC_CYC_SHORT 4'h6
// 13-bit mode prescaler width
`define DTC_PRESC_MASK 8'h1F

`endif

// file: dtc_pkg.sv
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_M13 = 2'h0,
        DTC_M16 = 2'h1,
        DTC_MRELOAD = 2'h2,
        DTC_MSPLIT = 2'h3
    } dtc_mode_e;

    typedef struct packed {
        logic gate;
        logic src;
        dtc_mode_e mode;
    } dtc_tcfg_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_s;

endpackage

// file: dtc_timer.sv
`timescale 1ns/1ns
`include "dtc_regs.svh"
// What this block does
// - timer function adds one each machine cycle while enabled
// - machine cycle is 12 oscillator periods if divider bit set, else 6
// - counter function samples event pin once per machine cycle, counts high-then-low
// - count from detected edge shows in register one machine cycle later
// - edge recognition takes two machine cycles, max rate osc/24 or osc/12
// - event pins sampled in the last period of each machine cycle, periods 12, 24, 36, 48 with long cycle
// - source bit selects event pin when set, machine cycle when clear
// - count enabled when run bit and (gate bit clear or interrupt pin high)
// - gating leaves external interrupt pin behaviour untouched
// - setting run bit keeps current count
// - wrap sets overflow flag and raises interrupt request, except a timer 1 wrap while timer 0 is in mode 3
// - mode 0 is 13 bits: high byte over 5-bit low prescaler
// - mode 1 is mode 0 with full 16-bit cascade
// - mode 2 low byte counts, reloads from unchanged high byte on overflow
// - mode 3 timer 0 low own controls, high byte uses timer 1 run/flag
// - timer 1 in mode 3 holds its count
// - timer 1 auto-reload mode is reserved, not implemented
// - each timer 1 overflow pulses the serial port
// - mode writes and control run bits take effect at end of writing instruction; control flag bits at once
// - mode field 00 13-bit, 01 16-bit, 10 reload, 11 split or stop
// - overflow flag cleared by hardware on interrupt vector
module dtc_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // pins
    input wire logic event_pin0,
    input wire logic event_pin1,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    // processor side
    input wire logic instr_end,
    input wire logic vector0_ack,
    input wire logic vector1_ack,
    // outputs
    output logic timer0_irq,
    output logic timer1_irq,
    output logic serial_tick
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] mode_reg, mode_pend_reg;
    logic [7:0] ctrl_reg;
    logic t0_run_pend_reg, t1_run_pend_reg, cfg_pend_reg;
    logic afr_cdc_reg;
    dtc_pkg::dtc_count_s t0_reg, t1_reg;
    logic [3:0] osc_cnt_reg;
    logic [3:0] cyc_len;
    logic mcyc;
    logic ev0_s_reg, ev1_s_reg, ev0_p_reg, ev1_p_reg;
    logic ev0_fall, ev1_fall;
    logic ack_reg;
    logic [31:0] rd_reg;
    logic err_reg;
    dtc_pkg::dtc_tcfg_s cfg0, cfg1;
    logic en0, en1, en0h;
    logic inc0l, inc0h, inc1;
    logic ovf0, ovf1;
    logic [7:0] t0l_next, t0h_next;
    dtc_pkg::dtc_count_s t1_next;
    logic req, wr, rd, hit;
    logic [3:0] idx;

    assign cfg0 = mode_reg[3:0];
    assign cfg1 = mode_reg[7:4];

    ////////////////////////////////////////////////////////////////////////////
    // machine cycle enable
    assign cyc_len = afr_cdc_reg ? `DTC_CYC_LONG : `DTC_CYC_SHORT;
    // >= so a shorter cycle picked mid-count cannot run the counter past its end
    assign mcyc = (osc_cnt_reg >= cyc_len - 4'h1);

    always_ff @(posedge clk) begin
        if (rst || mcyc) begin
            osc_cnt_reg <= 4'h0;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 4'h1;
        end
    end

    // pins sampled at the last oscillator period of each machine cycle, which with
    // the long cycle lands in periods 12/24/36/48 counted from a machine cycle start
    always_ff @(posedge clk) begin
        if (rst) begin
            ev0_s_reg <= 1'b0;
            ev1_s_reg <= 1'b0;
            ev0_p_reg <= 1'b0;
            ev1_p_reg <= 1'b0;
        end else if (mcyc) begin
            ev0_s_reg <= event_pin0;
            ev1_s_reg <= event_pin1;
            ev0_p_reg <= ev0_s_reg;
            ev1_p_reg <= ev1_s_reg;
        end
    end

    // an edge seen across two samples counts on the next machine cycle,
    // so the source must hold each level a full machine cycle
    assign ev0_fall = ev0_p_reg && !ev0_s_reg;
    assign ev1_fall = ev1_p_reg && !ev1_s_reg;

    ////////////////////////////////////////////////////////////////////////////
    // count enables; interrupt pins are only read here, never altered
    function automatic logic count_in(input logic src, input logic fall);
        count_in = src ? fall : 1'b1;
    endfunction

    assign en0 = ctrl_reg[`DTC_CTRL_T0_RUN] &&
                 (!cfg0.gate || ext_irq0_pin);
    assign en1 = ctrl_reg[`DTC_CTRL_T1_RUN] &&
                 (!cfg1.gate || ext_irq1_pin);
    assign en0h = ctrl_reg[`DTC_CTRL_T1_RUN];

    assign inc0l = mcyc && en0 && count_in(cfg0.src, ev0_fall);
    assign inc0h = mcyc && en0h && (cfg0.mode == dtc_pkg::DTC_MSPLIT);
    // timer 1 holds in mode 3 and in the reserved reload mode
    assign inc1 = mcyc && en1 && count_in(cfg1.src, ev1_fall) &&
                  (cfg1.mode != dtc_pkg::DTC_MSPLIT) &&
                  (cfg1.mode != dtc_pkg::DTC_MRELOAD);

    ////////////////////////////////////////////////////////////////////////////
    // timer 0 next value and overflows
    always_comb begin
        t0l_next = t0_reg.low;
        t0h_next = t0_reg.high;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        if (inc0l) begin
            unique case (cfg0.mode)
                dtc_pkg::DTC_M13: begin
                    t0l_next = (t0_reg.low + 8'h01) & `DTC_PRESC_MASK;
                    if ((t0_reg.low & `DTC_PRESC_MASK) == `DTC_PRESC_MASK) begin
                        t0h_next = t0_reg.high + 8'h01;
                        ovf0 = (t0_reg.high == 8'hFF);
                    end
                end
                dtc_pkg::DTC_M16: begin
                    t0l_next = t0_reg.low + 8'h01;
                    if (t0_reg.low == 8'hFF) begin
                        t0h_next = t0_reg.high + 8'h01;
                        ovf0 = (t0_reg.high == 8'hFF);
                    end
                end
                dtc_pkg::DTC_MRELOAD: begin
                    ovf0 = (t0_reg.low == 8'hFF);
                    t0l_next = ovf0 ? t0_reg.high : t0_reg.low + 8'h01;
                end
                dtc_pkg::DTC_MSPLIT: begin
                    t0l_next = t0_reg.low + 8'h01;
                    ovf0 = (t0_reg.low == 8'hFF);
                end
            endcase
        end
        if (inc0h) begin
            t0h_next = t0_reg.high + 8'h01;
            ovf1 = (t0_reg.high == 8'hFF);
        end
    end

    // timer 1 next value
    always_comb begin
        t1_next = t1_reg;
        if (inc1) begin
            if (cfg1.mode == dtc_pkg::DTC_M13) begin
                t1_next.low = (t1_reg.low + 8'h01) & `DTC_PRESC_MASK;
                if ((t1_reg.low & `DTC_PRESC_MASK) == `DTC_PRESC_MASK) begin
                    t1_next.high = t1_reg.high + 8'h01;
                end
            end else begin
                t1_next = t1_reg + 16'h0001;
            end
        end
    end

    // timer 1 wraps when its incremented value is zero
    logic t1_wrap;
    assign t1_wrap = inc1 && (t1_next == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode
    // an answer already standing blocks a second take of the same request
    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign idx = wb_adr_i[5:2];
    assign hit = (idx <= `DTC_IDX_AFR);
    assign wr = req && wb_we_i && hit && wb_sel_i[0];
    assign rd = req && !wb_we_i && hit;

    function automatic logic wr_to(input logic [3:0] target);
        wr_to = wr && (idx == target);
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= req && hit;
            err_reg <= req && !hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_reg <= 32'h0000_0000;
        end else if (rd) begin
            unique case (idx)
                `DTC_IDX_MODE: rd_reg <= {24'h000000, mode_reg};
                `DTC_IDX_CTRL: rd_reg <= {24'h000000, ctrl_reg};
                `DTC_IDX_T0L: rd_reg <= {24'h000000, t0_reg.low};
                `DTC_IDX_T0H: rd_reg <= {24'h000000, t0_reg.high};
                `DTC_IDX_T1L: rd_reg <= {24'h000000, t1_reg.low};
                `DTC_IDX_T1H: rd_reg <= {24'h000000, t1_reg.high};
                default: rd_reg <= {31'h00000000, afr_cdc_reg};
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rd_reg;

    ////////////////////////////////////////////////////////////////////////////
    // mode and run bits are staged and applied when the instruction ends
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_pend_reg <= `DTC_MODE_RESET;
            t0_run_pend_reg <= 1'b0;
            t1_run_pend_reg <= 1'b0;
            cfg_pend_reg <= 1'b0;
        end else if (wr_to(`DTC_IDX_MODE) || wr_to(`DTC_IDX_CTRL)) begin
            if (wr_to(`DTC_IDX_MODE)) begin
                mode_pend_reg <= wb_dat_i[7:0];
                t0_run_pend_reg <= ctrl_reg[`DTC_CTRL_T0_RUN];
                t1_run_pend_reg <= ctrl_reg[`DTC_CTRL_T1_RUN];
            end else begin
                mode_pend_reg <= mode_reg;
                t0_run_pend_reg <= wb_dat_i[`DTC_CTRL_T0_RUN];
                t1_run_pend_reg <= wb_dat_i[`DTC_CTRL_T1_RUN];
            end
            cfg_pend_reg <= 1'b1;
        end else if (instr_end) begin
            cfg_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= `DTC_MODE_RESET;
        end else if (cfg_pend_reg && instr_end) begin
            mode_reg <= mode_pend_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            afr_cdc_reg <= `DTC_AFR_RESET;
        end else if (wr_to(`DTC_IDX_AFR)) begin
            afr_cdc_reg <= wb_dat_i[`DTC_AFR_CDC];
        end
    end

    // run bits; flags set on wrap, set wins over vector clear and software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `DTC_CTRL_RESET;
        end else begin
            if (cfg_pend_reg && instr_end) begin
                ctrl_reg[`DTC_CTRL_T0_RUN] <= t0_run_pend_reg;
                ctrl_reg[`DTC_CTRL_T1_RUN] <= t1_run_pend_reg;
            end
            if (ovf0) begin
                ctrl_reg[`DTC_CTRL_T0_FLAG] <= 1'b1;
            end else if (vector0_ack) begin
                ctrl_reg[`DTC_CTRL_T0_FLAG] <= 1'b0;
            end else if (wr_to(`DTC_IDX_CTRL)) begin
                ctrl_reg[`DTC_CTRL_T0_FLAG] <= wb_dat_i[`DTC_CTRL_T0_FLAG];
            end
            if (ovf1 || (t1_wrap && cfg0.mode != dtc_pkg::DTC_MSPLIT)) begin
                ctrl_reg[`DTC_CTRL_T1_FLAG] <= 1'b1;
            end else if (vector1_ack) begin
                ctrl_reg[`DTC_CTRL_T1_FLAG] <= 1'b0;
            end else if (wr_to(`DTC_IDX_CTRL)) begin
                ctrl_reg[`DTC_CTRL_T1_FLAG] <= wb_dat_i[`DTC_CTRL_T1_FLAG];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters; a software byte write beats an increment in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            t0_reg <= 16'h0000;
        end else begin
            t0_reg.low <= wr_to(`DTC_IDX_T0L) ? wb_dat_i[7:0] : t0l_next;
            t0_reg.high <= wr_to(`DTC_IDX_T0H) ? wb_dat_i[7:0] : t0h_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t1_reg <= 16'h0000;
        end else begin
            t1_reg.low <= wr_to(`DTC_IDX_T1L) ? wb_dat_i[7:0] : t1_next.low;
            t1_reg.high <= wr_to(`DTC_IDX_T1H) ? wb_dat_i[7:0] : t1_next.high;
        end
    end

    // serial tick follows every timer 1 wrap, even when timer 0 owns its flag
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_tick <= 1'b0;
        end else begin
            serial_tick <= t1_wrap;
        end
    end

    assign timer0_irq = ctrl_reg[`DTC_CTRL_T0_FLAG];
    assign timer1_irq = ctrl_reg[`DTC_CTRL_T1_FLAG];

endmodule // dtc_timer

// file: dtc_timer_chk.sv
`timescale 1ns/1ns
module dtc_timer_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // processor side and outputs
    input wire logic vector0_ack,
    input wire logic vector1_ack,
    input wire logic timer0_irq,
    input wire logic timer1_irq,
    input wire logic serial_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    ////////////////////
    a_ack_mapped: assert property (s_take ##0 (wb_adr_i[5:2] <= 4'h6) |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked");
    a_err_unmapped: assert property (s_take ##0 (wb_adr_i[5:2] > 4'h6) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_answer_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("answer longer than one cycle");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    // wraps are a machine cycle apart, at least six clocks
    a_tick_spacing: assert property (serial_tick |=> !serial_tick [*5])
        else $error("serial tick too close");
    a_reset_quiet: assert property ($fell(rst) |-> !timer0_irq && !timer1_irq && !serial_tick)
        else $error("outputs active after reset");
    a_flag0_hold: assert property ($fell(timer0_irq) |-> $past(vector0_ack)
        || ($past(wb_we_i) && $past(wb_stb_i))) else $error("timer0 flag lost");
    a_flag1_hold: assert property ($fell(timer1_irq) |-> $past(vector1_ack)
        || ($past(wb_we_i) && $past(wb_stb_i))) else $error("timer1 flag lost");
endmodule // dtc_timer_chk

bind dtc_timer dtc_timer_chk u_chk (.clk(clk), .rst(rst), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .vector0_ack(vector0_ack),
    .vector1_ack(vector1_ack), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
    .serial_tick(serial_tick));

// file: dtc_event_src.sv
`timescale 1ns/1ns
module dtc_event_src #(
    parameter int HALF = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event line
    output logic pin
);
    int cnt_reg;
    // free-running source; HALF of 12 is the fastest legal rate with the long cycle, a deliberate edge case
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 0;
            pin <= 1'b1;
        end else if (cnt_reg == HALF - 1) begin
            cnt_reg <= 0;
            pin <= ~pin;
        end else begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule // dtc_event_src

// file: dual_timer_counter_tb.sv
`timescale 1ns/1ns
module dual_timer_counter_tb;
    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [7:0] d;
        logic [7:0] q;
        logic e;
    } dtc_row_s;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, instr_end;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic event_pin0, event_pin1, ext_irq0_pin, ext_irq1_pin, vector0_ack, vector1_ack;
    logic timer0_irq, timer1_irq, serial_tick, e;
    logic [7:0] v;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    dtc_row_s rows [10];
    dtc_timer dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .event_pin0, .event_pin1, .ext_irq0_pin,
        .ext_irq1_pin, .instr_end, .vector0_ack, .vector1_ack, .timer0_irq, .timer1_irq,
        .serial_tick);
    dtc_event_src #(.HALF(12)) src0 (.clk, .rst, .pin(event_pin0));
    dtc_event_src #(.HALF(20)) src1 (.clk, .rst, .pin(event_pin1));
    ////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; a write also ends the instruction so staged bits apply
    task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d,
        output logic [7:0] q, output logic er);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h000000, d};
        // only the bench timeout bounds this wait
        do begin
            @(posedge clk);
        end while (!(wb_ack_o || wb_err_o));
        q = wb_dat_o[7:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        instr_end <= we;
        @(posedge clk);
        instr_end <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, v, e);
    endtask
    task automatic rd(input logic [3:0] idx);
        wb(1'b0, idx, 8'h00, v, e);
    endtask
    // clear timer 0, run it for 240 clocks, stop and check the low byte lies in range
    task automatic mchk(input logic [7:0] m, c, input logic g, input logic [7:0] lo, hi);
        ext_irq0_pin <= g;
        wr(4'h1, 8'h00);
        wr(4'h6, c);
        wr(4'h0, m);
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h10);
        repeat (240) @(posedge clk);
        wr(4'h1, 8'h00);
        rd(4'h2);
        chk({7'h00, v >= lo && v <= hi}, 8'h01);
        $display("count test mode %h done", m);
    endtask
    ////////////////////
    initial begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, instr_end, vector0_ack, vector1_ack} = 7'h40;
        {wb_adr_i, wb_dat_i, wb_sel_i, ext_irq0_pin, ext_irq1_pin} = {38'h0, 4'hF, 2'h3};
        rows = '{'{0, 0, 0, 8'h00, 0}, '{0, 1, 0, 8'h00, 0}, '{0, 6, 0, 8'h01, 0},
            '{1, 2, 8'hFF, 0, 0}, '{0, 2, 0, 8'hFF, 0}, '{1, 0, 8'h01, 0, 0},
            '{1, 2, 8'hFF, 0, 0}, '{0, 2, 0, 8'hFF, 0}, '{0, 7, 0, 8'hFF, 1},
            '{1, 15, 0, 0, 1}};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].idx, rows[i].d, v, e);
            if (!rows[i].we) chk(v, rows[i].q);
            chk({7'h00, e}, {7'h00, rows[i].e});
        end
        $display("register table done");
        mchk(8'h01, 8'h00, 1'b1, 8'h27, 8'h29);
        mchk(8'h00, 8'h00, 1'b1, 8'h07, 8'h09);
        rd(4'h3);
        chk(v, 8'h01);
        mchk(8'h01, 8'h01, 1'b1, 8'h13, 8'h15);
        mchk(8'h05, 8'h01, 1'b1, 8'h09, 8'h0B);
        mchk(8'h0D, 8'h01, 1'b0, 8'h00, 8'h00);
        mchk(8'h0D, 8'h01, 1'b1, 8'h09, 8'h0B);
        wr(4'h0, 8'h01);
        wr(4'h3, 8'hFF);
        wr(4'h2, 8'hF0);
        wr(4'h1, 8'h10);
        repeat (150) @(posedge clk);
        chk({7'h00, timer0_irq}, 8'h00);
        for (int i = 0; i < 60 && !timer0_irq; i++) @(posedge clk);
        chk({7'h00, timer0_irq}, 8'h01);
        rd(4'h3);
        chk(v, 8'h00);
        vector0_ack <= 1'b1;
        @(posedge clk);
        vector0_ack <= 1'b0;
        @(posedge clk);
        chk({7'h00, timer0_irq}, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h02);
        wr(4'h3, 8'hF0);
        wr(4'h2, 8'hFE);
        wr(4'h1, 8'h10);
        for (int i = 0; i < 60 && !timer0_irq; i++) @(posedge clk);
        chk({7'h00, timer0_irq}, 8'h01);
        wr(4'h1, 8'h00);
        rd(4'h3);
        chk(v, 8'hF0);
        rd(4'h2);
        chk({7'h00, v >= 8'hF0 && v <= 8'hF4}, 8'h01);
        for (int k = 0; k < 3; k++) begin
            ext_irq1_pin <= (k != 2);
            wr(4'h0, (k == 2) ? 8'h90 : (k ? 8'h20 : 8'h30));
            wr(4'h4, 8'h55);
            wr(4'h1, 8'h40);
            repeat (100) @(posedge clk);
            rd(4'h4);
            chk(v, 8'h55);
            wr(4'h1, 8'h00);
        end
        wr(4'h0, 8'h10);
        wr(4'h5, 8'hFF);
        wr(4'h4, 8'hFE);
        wr(4'h1, 8'h40);
        for (int i = 0; i < 60 && !serial_tick; i++) @(posedge clk);
        chk({7'h00, serial_tick}, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, timer1_irq}, 8'h01);
        vector1_ack <= 1'b1;
        @(posedge clk);
        vector1_ack <= 1'b0;
        @(posedge clk);
        chk({7'h00, timer1_irq}, 8'h00);
        $display("overflow tests done");
        // split mode: high byte runs on timer 1 run bit and owns timer 1 flag
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h03);
        wr(4'h2, 8'h33);
        wr(4'h3, 8'hFE);
        wr(4'h1, 8'h40);
        for (int i = 0; i < 60 && !timer1_irq; i++) @(posedge clk);
        chk({7'h00, timer1_irq}, 8'h01);
        chk({7'h00, timer0_irq}, 8'h00);
        rd(4'h2);
        chk(v, 8'h33);
        $display("split mode test done");
        // reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0);
        chk(v, 8'h00);
        rd(4'h6);
        chk(v, 8'h01);
        chk({7'h00, timer1_irq}, 8'h00);
        $display("reset test done");
        end_of_test();
    end
endmodule // dual_timer_counter_tb
